/* File: xmb_regs.svh */
// register offsets, field positions, reset values, command bits and write mode codes of the external memory bus
`ifndef XMB_REGS_SVH
`define XMB_REGS_SVH

`define XMB_OFF_CTRL        12'h000
`define XMB_OFF_LATCH       12'h004
`define XMB_OFF_PTR         12'h008
`define XMB_OFF_CMD         12'h00c
`define XMB_OFF_STATUS      12'h010
`define XMB_OFF_RDATA       12'h014
`define XMB_OFF_PORT        12'h018
`define XMB_OFF_PORTOE      12'h01c

`define XMB_CTRL_BUSDIS     7
`define XMB_CTRL_WAIT_LO    4
`define XMB_CTRL_WM_LO      0
`define XMB_CTRL_RESET      8'h00

`define XMB_CMD_WRITE       0
`define XMB_CMD_READ        1
`define XMB_CMD_FETCH       2
`define XMB_CMD_EXTSRC      3
`define XMB_CMD_SLEEP       4

`define XMB_WM_BYTEWR       2'h0
`define XMB_WM_BYTESEL      2'h1

`endif

/* File: xmb_pkg.sv */
// types of the external memory bus block
package xmb_pkg;
	typedef enum logic [2:0] {
		XMB_IDLE  = 3'b000,
		XMB_ALE   = 3'b001,
		XMB_ADDR  = 3'b010,
		XMB_WAIT  = 3'b011,
		XMB_DATA  = 3'b100,
		XMB_DONE  = 3'b101
	} xmb_state_t;

	typedef struct packed {
		logic ub;
		logic lb;
		logic ce;
		logic ba0;
		logic write_high_strobe;
		logic write_low_strobe;
		logic oe;
		logic ale;
	} xmb_ctl_t;
endpackage

/* File: xmb_bus.sv */
// external memory bus controller with apb register slave
//
// Behaviour
// - access with bus disabled still uses bus
// - disable waits for branch to internal memory
// - idle internal execution: pins parked, tri-stated
// - each bus pin shared with port bit
// - sixteen-bit only, mode fixed by configuration
// - latch strobe marks address, oe reads word
// - chip enable low on access, high asleep
// - byte write pulses exactly one write strobe
// - word write even: hold byte, no strobe
// - word write odd: latch high, held low
// - word write odd: high strobe, ba0 mirrors, both enables
// - byte select: both halves, high strobe only
// - byte select: ba0 and enables from pointer
// - disable bit one gives ports, zero bus
// - wait field adds three minus code cycles, none on fetch
// - write mode field selects table write mode
//
// The APB slave port and the placing of the registers were left to the implementer.
`include "xmb_regs.svh"

module xmb_bus import xmb_pkg::*; #(
	parameter logic cfgExtMode = 1'b1
) (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        clkEn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [15:0] adIn,
	output logic      [15:0] adOut,
	output logic      [15:0] adOe_n,
	output logic      [3:0]  addrHi,
	output logic      [3:0]  addrHiOe_n,
	output logic      [7:0]  ctlOut,
	output logic      [7:0]  ctlOe_n
);
	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [7:0]  ctrl_q;
	logic        busDis_q;
	logic [7:0]  latch_q;
	logic [19:0] ptr_q;
	logic        extSrc_q;
	logic        sleep_q;
	logic [15:0] rdata_q;
	logic [7:0]  hold_q;
	logic [27:0] port_q;
	logic [27:0] portOe_q;
	xmb_state_t  state_q;
	logic [1:0]  waitCnt_q;
	logic        isWrite_q;
	logic        isFetch_q;
	logic        apbDone_q;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	xmb_ctl_t    ctl_q;
	logic [15:0] adOut_q;
	logic        adDrive_q;
	logic [3:0]  addrHi_q;
	logic        busOwn_q;

	wire logic       apbAcc = psel & penable & ~apbDone_q;
	wire logic       apbWr  = apbAcc & pwrite;
	wire logic [1:0] wm     = ctrl_q[`XMB_CTRL_WM_LO +: 2];
	wire logic       busy   = state_q != XMB_IDLE;

	function automatic logic [1:0] waitCycles(input logic [1:0] code);
		waitCycles = 2'h3 - code;
	endfunction

	// ----------------------------------------------------------------
	// apb slave: access phase with one wait state, answer registered at the first edge
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			apbDone_q <= 1'b0;
			prdata_q  <= 32'h0;
			pslverr_q <= 1'b0;
		end else if (clkEn) begin
			apbDone_q <= apbAcc;
			pslverr_q <= 1'b0;
			if (apbAcc && !pwrite) begin
				case (paddr)
					`XMB_OFF_CTRL:   prdata_q <= {24'h0, ctrl_q[7], 1'b0, ctrl_q[5:4], 2'h0,
						ctrl_q[1:0]};
					`XMB_OFF_LATCH:  prdata_q <= {24'h0, latch_q};
					`XMB_OFF_PTR:    prdata_q <= {12'h0, ptr_q};
					`XMB_OFF_STATUS: prdata_q <= {26'h0, busOwn_q, busDis_q, sleep_q, extSrc_q,
						busy, cfgExtMode};
					`XMB_OFF_RDATA:  prdata_q <= {16'h0, rdata_q};
					`XMB_OFF_PORT:   prdata_q <= {4'h0, port_q};
					`XMB_OFF_PORTOE: prdata_q <= {4'h0, portOe_q};
					default:         prdata_q <= 32'h0;
				endcase
			end
			if (apbAcc && !(paddr inside {`XMB_OFF_CTRL, `XMB_OFF_LATCH, `XMB_OFF_PTR,
				`XMB_OFF_CMD, `XMB_OFF_STATUS, `XMB_OFF_RDATA, `XMB_OFF_PORT,
				`XMB_OFF_PORTOE}))
				pslverr_q <= 1'b1;
		end
	end

	// pready sits high one cycle after penable: access takes two edges
	assign pready  = apbDone_q;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;

	// ----------------------------------------------------------------
	// software-written registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q   <= `XMB_CTRL_RESET;
			latch_q  <= 8'h0;
			ptr_q    <= 20'h0;
			extSrc_q <= 1'b0;
			sleep_q  <= 1'b0;
			port_q   <= 28'h0;
			portOe_q <= 28'hfffffff;
		end else if (clkEn) begin
			if (apbWr) begin
				case (paddr)
					`XMB_OFF_CTRL:   ctrl_q   <= pwdata[7:0] & 8'hb3;
					`XMB_OFF_LATCH:  latch_q  <= pwdata[7:0];
					`XMB_OFF_PTR:    ptr_q    <= pwdata[19:0];
					`XMB_OFF_PORT:   port_q   <= pwdata[27:0];
					`XMB_OFF_PORTOE: portOe_q <= pwdata[27:0];
					`XMB_OFF_CMD: begin
						extSrc_q <= pwdata[`XMB_CMD_EXTSRC];
						sleep_q  <= pwdata[`XMB_CMD_SLEEP];
					end
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// disable bit: deferred while code runs from external memory
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			busDis_q <= 1'b0;
		end else if (clkEn) begin
			if (!extSrc_q)
				busDis_q <= ctrl_q[`XMB_CTRL_BUSDIS];
		end
	end

	// ----------------------------------------------------------------
	// bus cycle sequencer
	// ----------------------------------------------------------------
	wire logic cmdGo = apbWr && paddr == `XMB_OFF_CMD && !busy && cfgExtMode && !sleep_q &&
		(pwdata[`XMB_CMD_WRITE] | pwdata[`XMB_CMD_READ] | pwdata[`XMB_CMD_FETCH]);

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_q   <= XMB_IDLE;
			waitCnt_q <= 2'h0;
			isWrite_q <= 1'b0;
			isFetch_q <= 1'b0;
		end else if (clkEn) begin
			case (state_q)
				XMB_IDLE: begin
					if (cmdGo) begin
						state_q   <= XMB_ALE;
						isWrite_q <= pwdata[`XMB_CMD_WRITE];
						isFetch_q <= pwdata[`XMB_CMD_FETCH];
					end
				end
				XMB_ALE:  state_q <= XMB_ADDR;
				XMB_ADDR: begin
					waitCnt_q <= isFetch_q ? 2'h0 : waitCycles(ctrl_q[`XMB_CTRL_WAIT_LO +: 2]);
					state_q   <= XMB_WAIT;
				end
				XMB_WAIT: begin
					if (waitCnt_q == 2'h0)
						state_q <= XMB_DATA;
					else
						waitCnt_q <= waitCnt_q - 2'h1;
				end
				XMB_DATA: state_q <= XMB_DONE;
				XMB_DONE: state_q <= XMB_IDLE;
				default:  state_q <= XMB_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// word write holding byte and read capture
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			hold_q  <= 8'h0;
			rdata_q <= 16'h0;
		end else if (clkEn && state_q == XMB_DATA) begin
			if (isWrite_q && wm[1] && !ptr_q[0])
				hold_q <= latch_q;
			if (!isWrite_q)
				rdata_q <= adIn;
		end
	end

	// ----------------------------------------------------------------
	// pin drive: bus owns pins during a cycle, else ports or parked
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ctl_q     <= '{ub: 1'b1, lb: 1'b1, ce: 1'b1, ba0: 1'b0, write_high_strobe: 1'b1, write_low_strobe: 1'b1,
				oe: 1'b1, ale: 1'b0};
			adOut_q   <= 16'h0;
			adDrive_q <= 1'b0;
			addrHi_q  <= 4'h0;
			busOwn_q  <= 1'b0;
		end else if (clkEn) begin
			// a cycle owns the pins even with the bus disabled
			busOwn_q  <= busy || !busDis_q;
			ctl_q     <= '{ub: 1'b1, lb: 1'b1, ce: 1'b1, ba0: 1'b0, write_high_strobe: 1'b1, write_low_strobe: 1'b1,
				oe: 1'b1, ale: 1'b0};
			adDrive_q <= 1'b0;
			if (busy && !sleep_q) begin
				ctl_q.ce   <= 1'b0;
				addrHi_q   <= ptr_q[19:16];
				ctl_q.ba0  <= ptr_q[0];
				if (state_q == XMB_ALE || state_q == XMB_ADDR) begin
					adDrive_q <= 1'b1;
					adOut_q   <= {ptr_q[15:1], 1'b0};
					ctl_q.ale <= state_q == XMB_ALE;
				end else if (!isWrite_q) begin
					ctl_q.oe <= 1'b0;
					ctl_q.ub <= 1'b0;
					ctl_q.lb <= 1'b0;
				end else if (wm == `XMB_WM_BYTEWR) begin
					adDrive_q <= 1'b1;
					adOut_q   <= {latch_q, latch_q};
					if (state_q == XMB_DATA) begin
						ctl_q.write_low_strobe <= ptr_q[0];
						ctl_q.write_high_strobe <= !ptr_q[0];
					end
				end else if (wm == `XMB_WM_BYTESEL) begin
					adDrive_q <= 1'b1;
					adOut_q   <= {latch_q, latch_q};
					ctl_q.ub  <= !ptr_q[0];
					ctl_q.lb  <= ptr_q[0];
					if (state_q == XMB_DATA)
						ctl_q.write_high_strobe <= 1'b0;
				end else if (ptr_q[0]) begin
					adDrive_q <= 1'b1;
					adOut_q   <= {latch_q, hold_q};
					ctl_q.ub  <= 1'b0;
					ctl_q.lb  <= 1'b0;
					if (state_q == XMB_DATA)
						ctl_q.write_high_strobe <= 1'b0;
				end
				// even word write leaves bus tri-stated, no strobe
			end
		end
	end

	// shared pins: bus functions or the port latches of the same bits
	always_comb begin
		if (busOwn_q && cfgExtMode) begin
			adOut      = adOut_q;
			adOe_n     = {16{!adDrive_q}};
			addrHi     = addrHi_q;
			addrHiOe_n = {4{!(adDrive_q || (ctl_q.ce == 1'b0))}};
			ctlOut     = ctl_q;
			ctlOe_n    = 8'h00;
		end else begin
			adOut      = port_q[15:0];
			adOe_n     = portOe_q[15:0];
			addrHi     = port_q[19:16];
			addrHiOe_n = portOe_q[19:16];
			ctlOut     = port_q[27:20];
			ctlOe_n    = portOe_q[27:20];
		end
	end
endmodule

/* File: xmb_bus_asserts.sv */
// pin-level checks of the external memory bus controller
module xmb_bus_asserts import xmb_pkg::*; (
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic [15:0] adOut,
	input wire logic [15:0] adOe_n,
	input wire logic [3:0]  addrHiOe_n,
	input wire logic [7:0]  ctlOut,
	input wire logic [7:0]  ctlOe_n
);
	// ----
	// bus-owned pin relations
	// ----
	xmb_ctl_t c;
	logic     on;
	assign c  = ctlOut;
	assign on = ctlOe_n == 8'h00;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	chk_wr_onehot: assert property (on |-> c.write_high_strobe || c.write_low_strobe)
		else $error("both write strobes low");
	chk_ale_addr: assert property (on && c.ale |-> !c.ce && adOe_n == 16'h0000)
		else $error("address latch without driven address");
	chk_ale_pulse: assert property (on && c.ale |=> !c.ale && !c.ce && $stable(c.ba0))
		else $error("latch strobe longer than one cycle");
	chk_oe_word: assert property (on && !c.oe |-> !c.ub && !c.lb && adOe_n == 16'hffff)
		else $error("read does not enable both bytes");
	chk_wr_ce: assert property (on && !(c.write_high_strobe && c.write_low_strobe) |-> !c.ce)
		else $error("write strobe outside chip enable");
	chk_park_idle: assert property (on && c.ce |-> ctlOut == 8'hee && &adOe_n && &addrHiOe_n)
		else $error("idle pins not parked");
	chk_wrl_dup: assert property (on && !c.write_low_strobe |-> adOe_n == 16'h0000 &&
		adOut[15:8] == adOut[7:0])
		else $error("low write without duplicated byte");
	chk_wrh_drive: assert property (on && !c.write_high_strobe |-> adOe_n == 16'h0000 && c.oe)
		else $error("high write without driven data");
endmodule

bind xmb_bus xmb_bus_asserts xmb_bus_asserts_i (.clk_sys, .reset_n, .adOut, .adOe_n,
	.addrHiOe_n, .ctlOut, .ctlOe_n);

/* File: xmb_mem_model.sv */
// word-wide external memory answering bus reads
module xmb_mem_model (
	input  wire logic        clk_sys,
	input  wire logic [15:0] adOut,
	input  wire logic [7:0]  ctlOut,
	output logic      [15:0] adIn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] addr_q = 16'h0000;
	logic [15:0] junk_q = 16'h0000;
	always @(posedge clk_sys) begin
		if (ctlOut[0])
			addr_q <= adOut;
		junk_q <= ~junk_q;
	end
	// released bus shows a toggling pattern so a late sample cannot match
	assign adIn = (!ctlOut[1] && !ctlOut[5]) ? addr_q ^ 16'hc35a : junk_q;
endmodule

/* File: tb_xmb_bus.sv */
// self-checking bench of the external memory bus controller
`include "xmb_regs.svh"
module tb_xmb_bus import xmb_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, rdErr, sh, sl, ub, lb, ba, eh, el, pb;
	logic [15:0] adIn, adOut, adOe_n, wd;
	logic [3:0]  addrHi, addrHiOe_n, ah;
	logic [7:0]  ctlOut, ctlOe_n, lt;
	xmb_ctl_t    c;
	int          errors = 0, tests_run = 0, ceCnt = 0, c3, i, m;
	assign c = ctlOut;
	always #25 clk_sys = ~clk_sys;
	xmb_bus xmb_bus_i (.clk_sys, .reset_n, .clkEn(1'b1), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .adIn, .adOut, .adOe_n, .addrHi, .addrHiOe_n,
		.ctlOut, .ctlOe_n);
	xmb_mem_model xmb_mem_model_i (.clk_sys, .adOut, .ctlOut, .adIn);
	always @(posedge clk_sys) if (ctlOe_n == 8'h00) begin
		if (!c.ce) ceCnt++;
		if (c.ale) ah = addrHi;
		if (!c.write_high_strobe) begin
			sh = 1;
			wd = adOut;
			{ub, lb, ba} = {c.ub, c.lb, c.ba0};
		end
		if (!c.write_low_strobe) begin
			sl = 1;
			wd = adOut;
			ba = c.ba0;
		end
	end
	// ----
	// access tasks
	// ----
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic hang(int k);
		if (k >= 30) begin
			chk("wait bound", 0, 1);
			give_verdict();
		end
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		int k;
		@(posedge clk_sys);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk_sys);
		penable <= 1;
		for (k = 0; k < 30; k++) begin
			@(posedge clk_sys);
			if (pready === 1'b1) break;
		end
		hang(k);
		{rd, rdErr} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask
	task automatic run(logic [31:0] cmd);
		int k;
		{sh, sl, ceCnt} = 0;
		apb(1, `XMB_OFF_CMD, cmd);
		for (k = 0; k < 30; k++) begin
			apb(0, `XMB_OFF_STATUS, 0);
			if (rd[1] === 1'b0) break;
		end
		hang(k);
		repeat (2) @(posedge clk_sys);
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		reset_n <= 1;
		repeat (2) @(posedge clk_sys);
		chk("park ctl", 8'hee, ctlOut);
		chk("park ad oe", 16'hffff, adOe_n);
		apb(0, `XMB_OFF_CTRL, 0);
		chk("ctrl reset", `XMB_CTRL_RESET, rd);
		apb(0, 12'h020, 0);
		chk("unmapped", 1, rdErr);
		$display("test reset done");
		for (i = 0; i < 8; i++) begin
			{m, pb} = {i / 2, i[0]};
			lt = pb ? 8'h5a : 8'h3c;
			{eh, el} = {m == 1 || pb, m == 0 && !pb};
			apb(1, `XMB_OFF_CTRL, 32'h30 | m);
			apb(1, `XMB_OFF_LATCH, lt);
			apb(1, `XMB_OFF_PTR, 32'h51234 | pb);
			run(1);
			chk("wrh", eh, sh);
			chk("wrl", el, sl);
			if (eh || el) chk("data", m > 1 ? 16'h5a3c : {lt, lt}, wd);
			if (eh || el) chk("ba0", pb, ba);
			if (m > 0 && eh) chk("ub lb", m == 1 ? {~pb, pb} : 2'b00, {ub, lb});
			chk("addr hi", 4'h5, ah);
		end
		$display("test write modes done");
		for (i = 3; i >= 0; i--) begin
			apb(1, `XMB_OFF_CTRL, i << 4);
			apb(1, `XMB_OFF_PTR, 32'ha0f0 + i);
			run(2);
			if (i == 3) c3 = ceCnt;
			chk("wait cycles", c3 + 3 - i, ceCnt);
			apb(0, `XMB_OFF_RDATA, 0);
			chk("read word", (16'ha0f0 + (i & 2)) ^ 16'hc35a, rd[15:0]);
		end
		$display("test reads done");
		apb(1, `XMB_OFF_CMD, 32'h8);
		apb(1, `XMB_OFF_CTRL, 32'h80);
		apb(0, `XMB_OFF_STATUS, 0);
		chk("disable held", 0, rd[4]);
		apb(1, `XMB_OFF_CMD, 0);
		apb(0, `XMB_OFF_STATUS, 0);
		chk("disable applied", 1, rd[4]);
		apb(1, `XMB_OFF_PORT, 32'h5a5a);
		apb(1, `XMB_OFF_PORTOE, 32'h0ff00000);
		chk("port ad", 16'h5a5a, adOut);
		chk("port oe", 0, adOe_n);
		run(2);
		chk("access while off", 1, ceCnt > 0);
		apb(1, `XMB_OFF_CTRL, 0);
		run(32'h10);
		run(32'h14);
		chk("sleep ce", 1, c.ce);
		chk("sleep access", 0, ceCnt);
		$display("test disable and sleep done");
		give_verdict();
	end
endmodule
